/* hdl/port_adapter_pkg.sv */
// Constants and carrier types for the dual-port peripheral adapter
package port_adapter_pkg;

    // ------------------------------------------------------------
    // Register select codes (register_select_high, register_select_low)
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_FIRST_DATA = 2'h0;
    localparam logic [1:0] SEL_FIRST_CTL = 2'h1;
    localparam logic [1:0] SEL_SECOND_DATA = 2'h2;
    localparam logic [1:0] SEL_SECOND_CTL = 2'h3;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int CTL_IRQ_EN = 0;      // Edge-input flag gates the request output
    localparam int CTL_EDGE_RISE = 1;   // 1: rising edge of edge input is active
    localparam int CTL_DIR_ACCESS = 2;  // 1: data register, 0: direction register
    localparam int CTL_DUAL_IRQ_EN = 3; // Input mode: irq enable; manual output mode (bit 4 set): level
    localparam int CTL_DUAL_RISE = 4;   // Input mode: 1 = rising edge active
    localparam int CTL_DUAL_OUT = 5;    // 1: dual control line is an output
    localparam int CTL_WR_BITS = 6;     // Bits 0..5 are host writable
    localparam int CTL_FLAG_DUAL = 6;   // Flag set by dual control line
    localparam int CTL_FLAG_EDGE = 7;   // Flag set by edge input

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_CTL = 6'h00;
    localparam logic [1:0] RST_FLAGS = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic read_write;        // 1 read, 0 write
        logic chip_select_pos_a;
        logic chip_select_pos_b;
        logic chip_select_neg_n;
        logic [1:0] register_select; // {high, low}
        logic [7:0] data;
    } host_bus_t;

    typedef struct packed {
        logic [7:0] out;    // Output register
        logic [7:0] dir;    // Direction register, 1 = output
        logic [5:0] ctl;    // Writable control bits
        logic [1:0] flags;  // {edge flag, dual flag}
        logic edge_prev;
        logic dual_prev;
    } port_state_t;

    typedef struct packed {
        port_state_t first;
        port_state_t second;
        logic enable_prev;
        logic [7:0] read_data;
    } adapter_state_t;

endpackage

/* hdl/port_adapter.sv */
// Dual 8-bit peripheral port adapter with host register access
`timescale 1ns/100ps
`default_nettype none

module port_adapter
    import port_adapter_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire host_bus_t host_bus,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic first_interrupt_request_n_out,
    output logic first_interrupt_request_n_oe,
    output logic second_interrupt_request_n_out,
    output logic second_interrupt_request_n_oe,
    input wire logic [7:0] first_port_lines_in,
    output logic [7:0] first_port_lines_out,
    output logic [7:0] first_port_lines_oe,
    input wire logic [7:0] second_port_lines_in,
    output logic [7:0] second_port_lines_out,
    output logic [7:0] second_port_lines_oe,
    input wire logic first_edge_input,
    input wire logic second_edge_input,
    input wire logic first_dual_control_line_in,
    output logic first_dual_control_line_out,
    output logic first_dual_control_line_oe,
    input wire logic second_dual_control_line_in,
    output logic second_dual_control_line_out,
    output logic second_dual_control_line_oe
);

    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    adapter_state_t state_reg;
    adapter_state_t state_next;
    logic selected;
    logic enable_fall;
    logic wr_strobe;
    logic rd_strobe;

    // Chip select decode; host holds selects stable through the pulse
    assign selected = host_bus.chip_select_pos_a & host_bus.chip_select_pos_b
        & ~host_bus.chip_select_neg_n;
    // Trailing edge of enable, seen one cycle late through the sampled copy
    assign enable_fall = state_reg.enable_prev & ~host_bus.enable;
    assign wr_strobe = enable_fall & selected & ~host_bus.read_write;
    assign rd_strobe = enable_fall & selected & host_bus.read_write;

    // ------------------------------------------------------------
    // Per-port update, shared by both ports
    // ------------------------------------------------------------
    function automatic port_state_t update_port(
        input port_state_t p,
        input logic wr_data,
        input logic wr_ctl,
        input logic rd_data,
        input logic [7:0] wdata,
        input logic edge_in,
        input logic dual_in
    );
        port_state_t n;
        logic edge_hit;
        logic dual_hit;
        n = p;
        // Active transition of the edge input, polarity from bit 1
        edge_hit = p.ctl[CTL_EDGE_RISE] ? (edge_in & ~p.edge_prev)
            : (~edge_in & p.edge_prev);
        // Dual line only raises its flag while it is an input
        dual_hit = ~p.ctl[CTL_DUAL_OUT] & (p.ctl[CTL_DUAL_RISE] ? (dual_in & ~p.dual_prev)
            : (~dual_in & p.dual_prev));
        n.edge_prev = edge_in;
        n.dual_prev = dual_in;
        // Bit 2 steers data-location accesses to output or direction register
        if (wr_data) begin
            if (p.ctl[CTL_DIR_ACCESS]) begin
                n.out = wdata;
            end else begin
                n.dir = wdata;
            end
        end
        // Host writes only the low six bits; flags stay hardware owned
        if (wr_ctl) begin
            n.ctl = wdata[CTL_WR_BITS-1:0];
        end
        // Set wins over the read clear so a coincident event is kept
        n.flags[1] = edge_hit | (p.flags[1] & ~rd_data);
        n.flags[0] = dual_hit | (p.flags[0] & ~rd_data);
        return n;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic data_sel_a;
        logic data_sel_b;
        logic rd_clear_a;
        logic rd_clear_b;
        data_sel_a = (host_bus.register_select == SEL_FIRST_DATA);
        data_sel_b = (host_bus.register_select == SEL_SECOND_DATA);
        // Only a read of the peripheral data register clears flags
        rd_clear_a = rd_strobe & data_sel_a & state_reg.first.ctl[CTL_DIR_ACCESS];
        rd_clear_b = rd_strobe & data_sel_b & state_reg.second.ctl[CTL_DIR_ACCESS];
        state_next = state_reg;
        state_next.enable_prev = host_bus.enable;
        state_next.first = update_port(state_reg.first, wr_strobe & data_sel_a,
            wr_strobe & (host_bus.register_select == SEL_FIRST_CTL), rd_clear_a,
            host_bus.data, first_edge_input, first_dual_control_line_in);
        state_next.second = update_port(state_reg.second, wr_strobe & data_sel_b,
            wr_strobe & (host_bus.register_select == SEL_SECOND_CTL), rd_clear_b,
            host_bus.data, second_edge_input, second_dual_control_line_in);
        // Read mux, refreshed every cycle the pulse is up so it is settled at the edge
        unique case (host_bus.register_select)
            SEL_FIRST_DATA: begin
                // Port A reads the pins themselves, whatever the direction
                state_next.read_data = state_reg.first.ctl[CTL_DIR_ACCESS]
                    ? first_port_lines_in : state_reg.first.dir;
            end
            SEL_FIRST_CTL: begin
                state_next.read_data = {state_reg.first.flags, state_reg.first.ctl};
            end
            SEL_SECOND_DATA: begin
                // Port B reads its latch on outputs, so loaded pins read true
                state_next.read_data = state_reg.second.ctl[CTL_DIR_ACCESS]
                    ? ((state_reg.second.out & state_reg.second.dir)
                    | (second_port_lines_in & ~state_reg.second.dir))
                    : state_reg.second.dir;
            end
            SEL_SECOND_CTL: begin
                state_next.read_data = {state_reg.second.flags, state_reg.second.ctl};
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Host data bus: driven only during a selected read pulse
    assign host_data_out = state_reg.read_data;
    assign host_data_oe = selected & host_bus.read_write & host_bus.enable;

    // Port lines: each direction bit decides drive
    assign first_port_lines_out = state_reg.first.out;
    assign first_port_lines_oe = state_reg.first.dir;
    assign second_port_lines_out = state_reg.second.out;
    assign second_port_lines_oe = state_reg.second.dir;

    // Dual lines: manual output mode drives bit 3; handshake modes hold high
    assign first_dual_control_line_oe = state_reg.first.ctl[CTL_DUAL_OUT];
    assign first_dual_control_line_out = ~state_reg.first.ctl[CTL_DUAL_RISE]
        | state_reg.first.ctl[CTL_DUAL_IRQ_EN];
    assign second_dual_control_line_oe = state_reg.second.ctl[CTL_DUAL_OUT];
    assign second_dual_control_line_out = ~state_reg.second.ctl[CTL_DUAL_RISE]
        | state_reg.second.ctl[CTL_DUAL_IRQ_EN];

    // Open-drain requests: pull low when an enabled flag is up
    assign first_interrupt_request_n_out = 1'b0;
    assign first_interrupt_request_n_oe = (state_reg.first.flags[1] & state_reg.first.ctl[CTL_IRQ_EN])
        | (state_reg.first.flags[0] & state_reg.first.ctl[CTL_DUAL_IRQ_EN]
        & ~state_reg.first.ctl[CTL_DUAL_OUT]);
    assign second_interrupt_request_n_out = 1'b0;
    assign second_interrupt_request_n_oe = (state_reg.second.flags[1] & state_reg.second.ctl[CTL_IRQ_EN])
        | (state_reg.second.flags[0] & state_reg.second.ctl[CTL_DUAL_IRQ_EN]
        & ~state_reg.second.ctl[CTL_DUAL_OUT]);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Reset leaves every register zero, so all lines are inputs
    a_reset_clears: assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> (state_reg == '0) && (first_port_lines_oe == 8'h00))
        else $error("reset did not clear registers");

    // Write of a data location lands in the register picked by bit 2
    a_write_dir_reg: assert property (wr_strobe && host_bus.register_select == SEL_FIRST_DATA
        && !state_reg.first.ctl[CTL_DIR_ACCESS] |=> first_port_lines_oe == $past(host_bus.data))
        else $error("direction write to first port lost");

    a_write_out_b: assert property (wr_strobe && host_bus.register_select == SEL_SECOND_DATA
        && state_reg.second.ctl[CTL_DIR_ACCESS] |=> second_port_lines_out == $past(host_bus.data))
        else $error("output write to second port lost");

    // Control writes change only the low six bits
    a_ctl_write_low: assert property (wr_strobe && host_bus.register_select == SEL_SECOND_CTL
        |=> state_reg.second.ctl == $past(host_bus.data[5:0]))
        else $error("control write wrong");

    // A host write never raises a flag by itself
    a_flag_not_written: assert property (wr_strobe && state_reg.first.flags == 2'h0
        && state_reg.first.edge_prev == first_edge_input
        && state_reg.first.dual_prev == first_dual_control_line_in
        |=> state_reg.first.flags == 2'h0)
        else $error("flag set by host write");

    // Active edge of the edge input raises its flag next cycle
    a_edge_sets_flag: assert property (state_reg.first.ctl[CTL_EDGE_RISE]
        && first_edge_input && !state_reg.first.edge_prev |=> state_reg.first.flags[1])
        else $error("edge input flag not set");

    // Read of the data register clears flags when no new event arrives
    a_read_clears: assert property (rd_strobe && host_bus.register_select == SEL_SECOND_DATA
        && state_reg.second.ctl[CTL_DIR_ACCESS]
        && state_reg.second.edge_prev == second_edge_input
        && state_reg.second.dual_prev == second_dual_control_line_in
        |=> state_reg.second.flags == 2'h0)
        else $error("data read did not clear flags");

    // Flag with enable pulls the request within one cycle of the event
    a_irq_follows: assert property (state_reg.first.ctl[CTL_IRQ_EN]
        && state_reg.first.ctl[CTL_EDGE_RISE] && first_edge_input
        && !state_reg.first.edge_prev |=> first_interrupt_request_n_oe)
        else $error("request not raised on enabled edge");

    // Bus is released outside a selected read pulse
    a_bus_released: assert property (!(selected && host_bus.read_write && host_bus.enable)
        |-> !host_data_oe)
        else $error("data bus driven while not reading");

    // Port B read returns latch on output lines whatever the pins show
    a_latch_read_b: assert property (host_bus.enable && host_bus.register_select == SEL_SECOND_DATA
        && state_reg.second.ctl[CTL_DIR_ACCESS] && $stable(host_bus.register_select)
        |=> ((host_data_out ^ $past(state_reg.second.out)) & $past(state_reg.second.dir)) == 8'h00)
        else $error("second port read not from latch");

    // Port A read returns the pins, also on output lines
    a_pin_read_a: assert property (host_bus.enable && host_bus.register_select == SEL_FIRST_DATA
        && state_reg.first.ctl[CTL_DIR_ACCESS]
        |=> host_data_out == $past(first_port_lines_in))
        else $error("first port read not from pins");

    // Port lines float while input; dual line floats unless bit 5 set
    a_float_inputs: assert property ((second_port_lines_oe & ~state_reg.second.dir) == 8'h00
        && (second_dual_control_line_oe == state_reg.second.ctl[CTL_DUAL_OUT])
        && (first_dual_control_line_oe == state_reg.first.ctl[CTL_DUAL_OUT]))
        else $error("input line driven");

    // Manual output mode puts bit 3 on the dual line
    a_dual_manual: assert property (state_reg.second.ctl[CTL_DUAL_OUT] && state_reg.second.ctl[CTL_DUAL_RISE]
        |-> second_dual_control_line_out == state_reg.second.ctl[CTL_DUAL_IRQ_EN])
        else $error("dual line output level wrong");

    c_write_then_read: cover property (wr_strobe ##[1:20] rd_strobe);
    c_irq_raised: cover property (!first_interrupt_request_n_oe ##1 first_interrupt_request_n_oe);
    c_flag_cleared: cover property (state_reg.second.flags[1] ##1 !state_reg.second.flags[1]);
    c_dual_output: cover property (first_dual_control_line_oe && !first_dual_control_line_out);

endmodule

`default_nettype wire

/* tb/peripheral_model.sv */
// Peripheral-side model: resolves both port pin buses and the dual control lines
`timescale 1ns/100ps
`default_nettype none
module peripheral_model (
    input wire logic [1:0][7:0] dev_out,
    input wire logic [1:0][7:0] dev_oe,
    input wire logic [1:0][7:0] drv_val,
    input wire logic [1:0][7:0] drv_en,
    input wire logic [7:0] load_mask,
    input wire logic [7:0] load_val,
    input wire logic [1:0] dual_out,
    input wire logic [1:0] dual_oe,
    input wire logic [1:0] dual_val,
    output logic [1:0][7:0] pin,
    output logic [1:0] dual_pin
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // A heavy load may pull a driven line away from its latch value
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                if (dev_oe[p][i]) begin
                    pin[p][i] = load_mask[i] ? load_val[i] : dev_out[p][i];
                end else if (drv_en[p][i]) begin
                    pin[p][i] = drv_val[p][i];
                end else begin
                    // First port pulls up; second floats, never a stale copy
                    pin[p][i] = (p == 0) ? 1'b1 : ~drv_val[p][i];
                end
            end
        end
        dual_pin = (dual_oe & dual_out) | (~dual_oe & dual_val);
    end
endmodule
`default_nettype wire

/* tb/test_port_adapter.sv */
// Self-checking bench for the dual-port peripheral adapter
`timescale 1ns/100ps
`default_nettype none
module test_port_adapter;
    import port_adapter_pkg::*;
    typedef struct {logic rw; logic [1:0] rs; logic [7:0] d;} row_t;
    localparam host_bus_t IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 8'h00};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    host_bus_t hb = IDLE;
    logic [1:0] edge_in = 2'h0;
    logic [1:0] dual_val = 2'h3;
    logic [1:0][7:0] drv_val = 16'hC33C;
    logic [1:0][7:0] drv_en = 16'hFFFF;
    logic [7:0] load_mask = 8'h00;
    logic [7:0] load_val = 8'h00;
    logic [7:0] host_data_out;
    logic host_data_oe;
    logic [7:0] r;
    wire logic [1:0][7:0] dev_out, dev_oe, pin;
    wire logic [1:0] dual_out, dual_oe, dual_pin, irq_oe, irq_out;
    int failures = 0;
    int checked = 0;
    row_t rows [14] = '{'{0, 1, 8'h00}, '{0, 0, 8'hF0}, '{0, 3, 8'h00}, '{0, 2, 8'h0F}, '{1, 0, 8'hF0},
        '{1, 2, 8'h0F}, '{0, 1, 8'h3F}, '{1, 1, 8'h3F}, '{0, 1, 8'hC4}, '{0, 3, 8'h04}, '{0, 0, 8'hA5},
        '{0, 2, 8'h5A}, '{1, 0, 8'hAC}, '{1, 2, 8'hCA}};

    port_adapter i_port_adapter (.sys_clk(sys_clk), .rst(rst), .host_bus(hb), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .first_interrupt_request_n_out(irq_out[0]),
        .first_interrupt_request_n_oe(irq_oe[0]),
        .second_interrupt_request_n_out(irq_out[1]), .second_interrupt_request_n_oe(irq_oe[1]),
        .first_port_lines_in(pin[0]), .first_port_lines_out(dev_out[0]), .first_port_lines_oe(dev_oe[0]),
        .second_port_lines_in(pin[1]), .second_port_lines_out(dev_out[1]), .second_port_lines_oe(dev_oe[1]),
        .first_edge_input(edge_in[0]), .second_edge_input(edge_in[1]),
        .first_dual_control_line_in(dual_pin[0]), .first_dual_control_line_out(dual_out[0]),
        .first_dual_control_line_oe(dual_oe[0]), .second_dual_control_line_in(dual_pin[1]),
        .second_dual_control_line_out(dual_out[1]), .second_dual_control_line_oe(dual_oe[1]));

    peripheral_model i_peripheral_model (.dev_out(dev_out), .dev_oe(dev_oe), .drv_val(drv_val), .drv_en(drv_en),
        .load_mask(load_mask), .load_val(load_val), .dual_out(dual_out), .dual_oe(dual_oe), .dual_val(dual_val),
        .pin(pin), .dual_pin(dual_pin));

    // ------------------------------------------------------------
    // Clock, compare and bus tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test;
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Two high cycles let read data settle; selects held past the falling enable
    task automatic bus(input logic rw, input logic [1:0] rs, input logic [7:0] wd, input logic sel,
                       output logic [7:0] rd);
        @(posedge sys_clk);
        hb <= '{1'b1, rw, 1'b1, 1'b1, ~sel, rs, wd};
        repeat (2) @(posedge sys_clk);
        #1 rd = host_data_out;
        check("data_oe", {7'h0, host_data_oe}, {7'h0, rw & sel});
        @(posedge sys_clk);
        hb.enable <= 1'b0;
        repeat (2) @(posedge sys_clk);
        hb <= IDLE;
    endtask

    task automatic wr(input logic [1:0] rs, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b0, rs, d, 1'b1, dummy);
    endtask

    task automatic rd_chk(input string name, input logic [1:0] rs, input logic [7:0] exp);
        logic [7:0] got;
        bus(1'b1, rs, 8'h00, 1'b1, got);
        check(name, got, exp);
    endtask

    // Synchronous reset held for five cycles
    task automatic do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // Edge-input or dual-line stimulus is launched on the clock, then left to settle
    task automatic drive_line(input logic dual, input int p, input logic v);
        @(posedge sys_clk);
        if (dual) begin
            dual_val[p] <= v;
        end else begin
            edge_in[p] <= v;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    // Hang guard: the whole sequence needs only a few hundred cycles
    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        // Host sets direction and control first after reset
        for (int i = 0; i < 14; i++) begin
            bus(rows[i].rw, rows[i].rs, rows[i].d, 1'b1, r);
            if (rows[i].rw) check("row", r, rows[i].d);
        end
        check("a_oe", dev_oe[0], 8'hF0);
        check("a_out", dev_out[0], 8'hA5);
        check("b_oe", dev_oe[1], 8'h0F);
        check("b_out", dev_out[1], 8'h5A);
        // Loaded outputs: first port reports the pin, second the latch
        @(posedge sys_clk);
        load_mask <= 8'h81;
        load_val <= 8'h01;
        rd_chk("a_loaded", 2'h0, 8'h2C);
        rd_chk("b_loaded", 2'h2, 8'hCA);
        load_mask <= 8'h00;
        // Unselected write and read must leave everything alone
        bus(1'b0, 2'h0, 8'hFF, 1'b0, r);
        bus(1'b1, 2'h0, 8'h00, 1'b0, r);
        check("a_out_desel", dev_out[0], 8'hA5);
        for (int p = 0; p < 2; p++) begin
            wr({p[0], 1'b1}, 8'h07);
            drive_line(1'b0, p, 1'b1);
            check("irq_set", {7'h0, irq_oe[p]}, 8'h01);
            check("irq_level", {7'h0, irq_out[p]}, 8'h00);
            rd_chk("ctl_edge", {p[0], 1'b1}, 8'h87);
            rd_chk("data_clr", {p[0], 1'b0}, p ? 8'hCA : 8'hAC);
            rd_chk("ctl_clr", {p[0], 1'b1}, 8'h07);
            check("irq_clr", {7'h0, irq_oe[p]}, 8'h00);
            drive_line(1'b0, p, 1'b0);
            rd_chk("ctl_fall_off", {p[0], 1'b1}, 8'h07);
            wr({p[0], 1'b1}, 8'h05);
            drive_line(1'b0, p, 1'b1);
            drive_line(1'b0, p, 1'b0);
            rd_chk("ctl_fall_on", {p[0], 1'b1}, 8'h85);
            rd_chk("data_clr2", {p[0], 1'b0}, p ? 8'hCA : 8'hAC);
            wr({p[0], 1'b1}, 8'h0C);
            check("dual_in", {7'h0, dual_oe[p]}, 8'h00);
            drive_line(1'b1, p, 1'b0);
            rd_chk("ctl_dual", {p[0], 1'b1}, 8'h4C);
            check("irq_dual", {7'h0, irq_oe[p]}, 8'h01);
            wr({p[0], 1'b1}, 8'h38);
            check("dual_hi", {6'h0, dual_oe[p], dual_out[p]}, 8'h03);
            wr({p[0], 1'b1}, 8'h30);
            check("dual_lo", {6'h0, dual_oe[p], dual_out[p]}, 8'h02);
        end
        // Reset in mid-run clears every register and releases every line
        do_reset();
        check("oe_rst", dev_oe[0] | dev_oe[1], 8'h00);
        check("ctl_oe_rst", {4'h0, dual_oe, irq_oe}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            rd_chk("reg_rst", s[1:0], 8'h00);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
